// file: hw/mifc_defines.vh
`ifndef MIFC_DEFINES_VH
`define MIFC_DEFINES_VH
// register byte addresses on the axi4-lite slave
`define MIFC_ADDR_EDGE_SEL   8'h00
`define MIFC_ADDR_CTRL_A     8'h04
`define MIFC_ADDR_CTRL_B     8'h08
`define MIFC_ADDR_GROUP_0    8'h0c
`define MIFC_ADDR_GROUP_1    8'h10
`define MIFC_ADDR_IRQ_STAT   8'h14
`define MIFC_ADDR_IRQ_MASK   8'h18
`define MIFC_ADDR_POWER      8'h1c
// edge select encodings
`define MIFC_EDGE_OFF        2'b00
`define MIFC_EDGE_RISE       2'b01
`define MIFC_EDGE_FALL       2'b10
`define MIFC_EDGE_BOTH       2'b11
// primary control a field positions
`define MIFC_A_GIE           0
`define MIFC_A_PIN_EN        1
`define MIFC_A_TB0_EN        2
`define MIFC_A_TB1_EN        3
`define MIFC_A_PIN_F         4
`define MIFC_A_TB0_F         5
`define MIFC_A_TB1_F         6
// primary control b field positions
`define MIFC_B_G0_EN         0
`define MIFC_B_EE_EN         1
`define MIFC_B_G1_EN         3
`define MIFC_B_G0_F          4
`define MIFC_B_EE_F          5
`define MIFC_B_G1_F          7
// group register field positions
`define MIFC_G_CMPP_EN       0
`define MIFC_G_CMPA_EN       1
`define MIFC_G_CMPP_F        4
`define MIFC_G_CMPA_F        5
// implemented-bit masks
`define MIFC_MASK_EDGE       8'h03
`define MIFC_MASK_A          8'h7f
`define MIFC_MASK_B          8'hbb
`define MIFC_MASK_G          8'h33
// reset values
`define MIFC_RST_REG         8'h00
// interrupt vector codes, in priority order
`define MIFC_VEC_NONE        3'h0
`define MIFC_VEC_PIN         3'h1
`define MIFC_VEC_G0          3'h2
`define MIFC_VEC_TB0         3'h3
`define MIFC_VEC_TB1         3'h4
`define MIFC_VEC_EE          3'h5
`define MIFC_VEC_G1          3'h6
// axi responses
`define MIFC_RESP_OKAY       2'b00
`define MIFC_RESP_SLVERR     2'b10
`endif

// file: hw/mifc_group.v
`include "mifc_defines.vh"
`timescale 1ns/1ns
`default_nettype none
// one multi-function group: two compare-match flags and their enables
module mifc_group (
	input  wire       clk_i,      // system clock
	input  wire       rstn_i,     // sync reset, active low
	input  wire       ce_i,       // clock enable
	input  wire       cmpp_evt_i, // comparator p match pulse
	input  wire       cmpa_evt_i, // comparator a match pulse
	input  wire       wr_i,       // software write strobe
	input  wire [7:0] wdata_i,    // software write data
	output wire [7:0] rdata_o,    // register read view
	output wire       any_o       // group request (any member flag)
);
	reg [7:0] reg_q; // implemented bits only
	reg [7:0] reg_d; // next value

	// hardware set wins over software write in the same cycle
	always @* begin
		reg_d = reg_q;
		if (wr_i) begin
			reg_d = wdata_i & `MIFC_MASK_G; // see (R10)
		end
		if (cmpp_evt_i) begin
			reg_d[`MIFC_G_CMPP_F] = 1'b1; // see (R07)
		end
		if (cmpa_evt_i) begin
			reg_d[`MIFC_G_CMPA_F] = 1'b1; // see (R07)
		end
	end

	// state register
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			reg_q <= `MIFC_RST_REG; // see (R11)
		end else if (ce_i) begin
			reg_q <= reg_d;
		end
	end

	assign rdata_o = reg_q;
	// group request when any member flag stands, enabled or not
	assign any_o   = reg_q[`MIFC_G_CMPP_F] | reg_q[`MIFC_G_CMPA_F]; // see (R17)
endmodule
`default_nettype wire

// file: hw/mifc_top.v
// How it works
// (R01) edge select: off, rise, fall, both
// (R02) pin flag set on selected edge
// (R03) separate time base 1 and 0 flags
// (R04) eeprom flag and its enable bit
// (R05) group flags at control b bits 7,4
// (R06) group enables at control b bits 3,0
// (R07) timer a flags bits 4,5, enables 0,1
// (R08) time base enables at bits 3,2
// (R09) global enable bit 0, pin enable bit 1
// (R10) unimplemented bits read zero, ignore writes
// (R11) all flags and enables clear at reset
// (R12) timer compares feed group registers only
// (R13) flags set always, request needs both enables
// (R14) service clears global enable, flags still record
// (R15) pin flag cleared when pin serviced
// (R16) any flag wakes device from sleep
// (R17) group flag from members, fixed priority
`include "mifc_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module mifc_top (
	input  wire        clk_i,         // system clock 125 mhz
	input  wire        rstn_i,        // sync reset, active low
	input  wire        ce_i,          // clock enable, freezes state
	input  wire        ext_pin_i,     // external interrupt pin, async
	input  wire        tb0_evt_i,     // time base 0 event pulse
	input  wire        tb1_evt_i,     // time base 1 event pulse
	input  wire        ee_evt_i,      // eeprom write done pulse
	input  wire        ta_cmpp_i,     // timer a comparator p match pulse
	input  wire        ta_cmpa_i,     // timer a comparator a match pulse
	input  wire        tb_cmpp_i,     // timer b comparator p match pulse
	input  wire        tb_cmpa_i,     // timer b comparator a match pulse
	input  wire        svc_ack_i,     // core services current vector, pulse
	input  wire        low_power_i,   // device in sleep or idle
	input  wire [31:0] s_axi_awaddr,  // write address
	input  wire        s_axi_awvalid, // write address valid
	output reg         s_axi_awready, // write address ready
	input  wire [31:0] s_axi_wdata,   // write data
	input  wire [3:0]  s_axi_wstrb,   // write strobes
	input  wire        s_axi_wvalid,  // write data valid
	output reg         s_axi_wready,  // write data ready
	output reg  [1:0]  s_axi_bresp,   // write response
	output reg         s_axi_bvalid,  // write response valid
	input  wire        s_axi_bready,  // write response ready
	input  wire [31:0] s_axi_araddr,  // read address
	input  wire        s_axi_arvalid, // read address valid
	output reg         s_axi_arready, // read address ready
	output reg  [31:0] s_axi_rdata,   // read data
	output reg  [1:0]  s_axi_rresp,   // read response
	output reg         s_axi_rvalid,  // read data valid
	input  wire        s_axi_rready,  // read data ready
	output reg         core_req_o,    // interrupt request to core
	output reg  [2:0]  core_vec_o,    // winning vector code
	output reg         wake_o,        // wake-up to power control
	output reg         irq_o          // level interrupt to system
);
	reg [1:0] edge_q;     // edge select field
	reg [6:0] ctrl_a_q;   // primary control a
	reg [7:0] ctrl_b_q;   // primary control b (implemented bits)
	reg [2:0] stat_q;     // sticky event status: pin, eeprom, service
	reg [2:0] mask_q;     // mask, same layout
	reg [2:0] pin_sync_q; // two-flop sync plus last value
	reg       aw_hold_q;  // write address captured
	reg       w_hold_q;   // write data captured
	reg [7:0] aw_addr_q;  // captured write address
	reg [7:0] w_data_q;   // captured write data byte
	reg [7:0] ctrl_a_d;   // next control a
	reg [7:0] ctrl_b_d;   // next control b
	reg [7:0] rd_mux;     // read data mux
	reg       rd_hit;     // read address mapped
	reg [2:0] vec_d;      // priority result
	reg       wr_hit;     // write address mapped
	wire      pin_rise;   // synced rising edge
	wire      pin_fall;   // synced falling edge
	wire      pin_edge;   // selected edge seen
	wire      wr_go;      // write executes this cycle
	wire [7:0] g0_rd;     // group 0 read view
	wire [7:0] g1_rd;     // group 1 read view
	wire      g0_any;     // group 0 member request
	wire      g1_any;     // group 1 member request
	wire      svc_pin;    // pin vector serviced
	wire      svc_any;    // any vector serviced
	wire      grp0_wr;    // group 0 write strobe
	wire      grp1_wr;    // group 1 write strobe

	// write happens once both address and data are held and b channel free
	assign wr_go   = aw_hold_q & w_hold_q & ~s_axi_bvalid;
	assign grp0_wr = wr_go & wr_hit & (aw_addr_q == `MIFC_ADDR_GROUP_0);
	assign grp1_wr = wr_go & wr_hit & (aw_addr_q == `MIFC_ADDR_GROUP_1);
	assign svc_any = svc_ack_i & core_req_o;
	assign svc_pin = svc_any & (core_vec_o == `MIFC_VEC_PIN);

	// pin sync: stage 0 is read only by stage 1
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			pin_sync_q <= 3'h0;
		end else if (ce_i) begin
			pin_sync_q <= {pin_sync_q[1:0], ext_pin_i};
		end
	end
	assign pin_rise = pin_sync_q[1] & ~pin_sync_q[2];
	assign pin_fall = ~pin_sync_q[1] & pin_sync_q[2];
	// edge qualifier; 00 leaves the pin dead
	assign pin_edge = (edge_q[0] & pin_rise) | (edge_q[1] & pin_fall); // see (R01)

	// compare sources go to the group registers, never the primaries
	mifc_group u_grp0 (
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.cmpp_evt_i (ta_cmpp_i), // see (R12)
		.cmpa_evt_i (ta_cmpa_i),
		.wr_i       (grp0_wr),
		.wdata_i    (w_data_q),
		.rdata_o    (g0_rd),
		.any_o      (g0_any)
	);
	mifc_group u_grp1 (
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.cmpp_evt_i (tb_cmpp_i), // see (R12)
		.cmpa_evt_i (tb_cmpa_i),
		.wr_i       (grp1_wr),
		.wdata_i    (w_data_q),
		.rdata_o    (g1_rd),
		.any_o      (g1_any)
	);

	// write address decode
	always @* begin
		case (aw_addr_q)
			`MIFC_ADDR_EDGE_SEL, `MIFC_ADDR_CTRL_A, `MIFC_ADDR_CTRL_B,
			`MIFC_ADDR_GROUP_0, `MIFC_ADDR_GROUP_1, `MIFC_ADDR_IRQ_STAT,
			`MIFC_ADDR_IRQ_MASK, `MIFC_ADDR_POWER: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// next primary control values: software write, then hardware sets win
	always @* begin
		ctrl_a_d = {1'b0, ctrl_a_q};
		ctrl_b_d = ctrl_b_q;
		if (wr_go && aw_addr_q == `MIFC_ADDR_CTRL_A) begin
			ctrl_a_d = w_data_q & `MIFC_MASK_A; // see (R09) (R08) (R10)
		end
		if (wr_go && aw_addr_q == `MIFC_ADDR_CTRL_B) begin
			ctrl_b_d = w_data_q & `MIFC_MASK_B; // see (R06) (R04) (R10)
		end
		// servicing drops global enable; servicing the pin vector also drops the pin flag
		if (svc_any) begin
			ctrl_a_d[`MIFC_A_GIE] = 1'b0; // see (R14)
		end
		if (svc_pin) begin
			ctrl_a_d[`MIFC_A_PIN_F] = 1'b0; // see (R15)
		end
		// flags record regardless of enables
		if (pin_edge) begin
			ctrl_a_d[`MIFC_A_PIN_F] = 1'b1; // see (R02) (R13)
		end
		if (tb0_evt_i) begin
			ctrl_a_d[`MIFC_A_TB0_F] = 1'b1; // see (R03)
		end
		if (tb1_evt_i) begin
			ctrl_a_d[`MIFC_A_TB1_F] = 1'b1; // see (R03)
		end
		if (ee_evt_i) begin
			ctrl_b_d[`MIFC_B_EE_F] = 1'b1; // see (R04)
		end
		// group flag rises when any member flag stands
		if (g0_any) begin
			ctrl_b_d[`MIFC_B_G0_F] = 1'b1; // see (R05) (R17)
		end
		if (g1_any) begin
			ctrl_b_d[`MIFC_B_G1_F] = 1'b1; // see (R05) (R17)
		end
	end

	// fixed priority among enabled pending requests
	always @* begin
		vec_d = `MIFC_VEC_NONE;
		if (ctrl_a_q[`MIFC_A_PIN_F] & ctrl_a_q[`MIFC_A_PIN_EN]) begin
			vec_d = `MIFC_VEC_PIN; // see (R17)
		end else if (ctrl_b_q[`MIFC_B_G0_F] & ctrl_b_q[`MIFC_B_G0_EN]) begin
			vec_d = `MIFC_VEC_G0;
		end else if (ctrl_a_q[`MIFC_A_TB0_F] & ctrl_a_q[`MIFC_A_TB0_EN]) begin
			vec_d = `MIFC_VEC_TB0;
		end else if (ctrl_a_q[`MIFC_A_TB1_F] & ctrl_a_q[`MIFC_A_TB1_EN]) begin
			vec_d = `MIFC_VEC_TB1;
		end else if (ctrl_b_q[`MIFC_B_EE_F] & ctrl_b_q[`MIFC_B_EE_EN]) begin
			vec_d = `MIFC_VEC_EE;
		end else if (ctrl_b_q[`MIFC_B_G1_F] & ctrl_b_q[`MIFC_B_G1_EN]) begin
			vec_d = `MIFC_VEC_G1;
		end
	end

	// interrupt registers and core-facing outputs
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			edge_q     <= 2'b00; // see (R11)
			ctrl_a_q   <= 7'h00;
			ctrl_b_q   <= `MIFC_RST_REG; // see (R11)
			stat_q     <= 3'h0;
			mask_q     <= 3'h0;
			core_req_o <= 1'b0;
			core_vec_o <= `MIFC_VEC_NONE;
			wake_o     <= 1'b0;
			irq_o      <= 1'b0;
		end else if (ce_i) begin
			ctrl_a_q <= ctrl_a_d[6:0];
			ctrl_b_q <= ctrl_b_d;
			if (wr_go && aw_addr_q == `MIFC_ADDR_EDGE_SEL) begin
				edge_q <= w_data_q[1:0]; // see (R01) (R10)
			end
			if (wr_go && aw_addr_q == `MIFC_ADDR_IRQ_MASK) begin
				mask_q <= w_data_q[2:0];
			end
			// write-one-to-clear, new events win over the clear
			stat_q <= (stat_q & ~((wr_go && aw_addr_q == `MIFC_ADDR_IRQ_STAT) ?
				w_data_q[2:0] : 3'h0)) | {svc_any, ee_evt_i, pin_edge};
			irq_o  <= |(stat_q & mask_q);
			// request needs global enable; drop it the cycle after service
			core_req_o <= ctrl_a_q[`MIFC_A_GIE] & (vec_d != `MIFC_VEC_NONE)
				& ~svc_any; // see (R13) (R14)
			core_vec_o <= vec_d;
			wake_o <= low_power_i & ((|ctrl_a_q[6:4]) | ctrl_b_q[`MIFC_B_G0_F]
				| ctrl_b_q[`MIFC_B_EE_F] | ctrl_b_q[`MIFC_B_G1_F]); // see (R16)
		end
	end

	// read mux; unimplemented bits read zero
	always @* begin
		rd_hit = 1'b1;
		case (s_axi_araddr[7:0])
			`MIFC_ADDR_EDGE_SEL: rd_mux = {6'h00, edge_q}; // see (R10)
			`MIFC_ADDR_CTRL_A:   rd_mux = {1'b0, ctrl_a_q};
			`MIFC_ADDR_CTRL_B:   rd_mux = ctrl_b_q;
			`MIFC_ADDR_GROUP_0:  rd_mux = g0_rd;
			`MIFC_ADDR_GROUP_1:  rd_mux = g1_rd;
			`MIFC_ADDR_IRQ_STAT: rd_mux = {5'h00, stat_q};
			`MIFC_ADDR_IRQ_MASK: rd_mux = {5'h00, mask_q};
			`MIFC_ADDR_POWER:    rd_mux = {7'h00, wake_o};
			default: begin
				rd_mux = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
		if (|s_axi_araddr[31:8]) begin
			rd_hit = 1'b0;
		end
	end

	// axi4-lite slave; addr and data accepted in either order
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `MIFC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `MIFC_RESP_OKAY;
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 8'h00;
		end else if (ce_i) begin
			// ready pulses for one cycle on acceptance
			s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_hold_q <= 1'b1;
				// high address bits fold into an unmapped code
				aw_addr_q <= (|s_axi_awaddr[31:8]) ? 8'hff : s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_hold_q <= 1'b1;
				// only lane 0 is meaningful; masked lane writes zero
				w_data_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
			end
			if (wr_go) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `MIFC_RESP_OKAY : `MIFC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h000000, rd_mux};
				s_axi_rresp  <= rd_hit ? `MIFC_RESP_OKAY : `MIFC_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: test/mifc_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "mifc_defines.vh"
// port-level checks on the flag block
module mifc_monitor (
	input wire logic       clk_i,         // clock
	input wire logic       rstn_i,        // reset
	input wire logic       ce_i,          // run
	input wire logic       tb0_evt_i,     // event
	input wire logic       tb1_evt_i,     // event
	input wire logic       ee_evt_i,      // event
	input wire logic       svc_ack_i,     // service
	input wire logic       low_power_i,   // sleep
	input wire logic       s_axi_awready, // bus
	input wire logic       s_axi_bvalid,  // bus
	input wire logic       s_axi_bready,  // bus
	input wire logic       s_axi_arvalid, // bus
	input wire logic       s_axi_arready, // bus
	input wire logic       s_axi_rvalid,  // bus
	input wire logic       s_axi_rready,  // bus
	input wire logic       core_req_o,    // request
	input wire logic [2:0] core_vec_o,    // vector
	input wire logic       wake_o         // wake
);
	default clocking mc @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	// core takes the standing request
	sequence svc_s;
		core_req_o && svc_ack_i;
	endsequence
	// primary event lands in sleep, and sleep holds
	sequence nap_s;
		low_power_i && ce_i && (tb0_evt_i || tb1_evt_i || ee_evt_i) ##1 low_power_i;
	endsequence
	svc_drop_a: assert property (svc_s |=> !core_req_o)
		else $error("request stayed after service");
	nap_wake_a: assert property (nap_s |=> wake_o)
		else $error("no wake after event in sleep");
	wake_cause_a: assert property (wake_o |-> $past(low_power_i))
		else $error("wake without sleep");
	req_vector_a: assert property (core_req_o |-> core_vec_o != `MIFC_VEC_NONE)
		else $error("request without vector");
	vec_range_a: assert property (core_vec_o <= `MIFC_VEC_G1)
		else $error("vector out of range");
	bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	rresp_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("write address ready held");
endmodule
bind mifc_top mifc_monitor u_mon (.clk_i, .rstn_i, .ce_i, .tb0_evt_i, .tb1_evt_i, .ee_evt_i,
	.svc_ack_i, .low_power_i, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .core_req_o, .core_vec_o, .wake_o);
`default_nettype wire

// file: test/mifc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// core side: services a standing request after a chosen wait
module mifc_core_model (
	input  wire logic       clk_i,      // clock
	input  wire logic       rstn_i,     // reset, active low
	input  wire logic       core_req_i, // request from block
	input  wire logic [2:0] core_vec_i, // vector from block
	input  wire logic [3:0] dly_i,      // cycles to wait first
	output var  logic       svc_o,      // service pulse
	output var  logic [2:0] vec_o,      // last vector taken
	output var  logic [7:0] cnt_o       // services so far
);
	logic [3:0] wait_q; // cycles spent waiting
	// one-cycle pulse; no second take while the block drops its request
	always_ff @(posedge clk_i) begin
		svc_o <= 1'b0;
		if (!rstn_i) begin
			wait_q <= 4'h0;
			vec_o <= 3'h0;
			cnt_o <= 8'h0;
		end else if (core_req_i && !svc_o) begin
			if (wait_q >= dly_i) begin
				svc_o <= 1'b1;
				vec_o <= core_vec_i;
				cnt_o <= cnt_o + 8'h1;
				wait_q <= 4'h0;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end else begin
			wait_q <= 4'h0;
		end
	end
endmodule
`default_nettype wire

// file: test/mifc_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "mifc_defines.vh"
// self-checking bench for the interrupt flag block
module mifc_top_bench;
	logic        clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, ext_pin_i = 1'b0; // basics
	logic        low_power_i = 1'b0, svc_ack_i;                             // sleep, service
	logic [6:0]  ev = 7'h0;                                                 // event pulses
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;                                        // whole words
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;                             // responses
	logic [31:0] s_axi_rdata;                                               // read data
	logic        core_req_o, wake_o, irq_o;                                 // outputs
	logic [2:0]  core_vec_o, last_vec;                                      // vectors
	logic [7:0]  svc_cnt, rd;                                               // counts, read byte
	logic [3:0]  dly = 4'h0;                                                // core wait
	int          n_mismatch = 0, check_count = 0;                           // tallies
	mifc_top dut (.clk_i, .rstn_i, .ce_i, .ext_pin_i, .tb0_evt_i(ev[0]), .tb1_evt_i(ev[1]),
		.ee_evt_i(ev[2]), .ta_cmpp_i(ev[3]), .ta_cmpa_i(ev[4]), .tb_cmpp_i(ev[5]),
		.tb_cmpa_i(ev[6]), .svc_ack_i, .low_power_i, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.core_req_o, .core_vec_o, .wake_o, .irq_o);
	mifc_core_model core (.clk_i, .rstn_i, .core_req_i(core_req_o), .core_vec_i(core_vec_o),
		.dly_i(dly), .svc_o(svc_ack_i), .vec_o(last_vec), .cnt_o(svc_cnt));
	always #4 clk_i = ~clk_i;
	// implemented bits above, plain enable bits below
	function automatic logic [15:0] msk(input int k);
		case (k)
			0: return {`MIFC_MASK_EDGE, 8'h03};
			1: return {`MIFC_MASK_A, 8'h0e};
			2: return {`MIFC_MASK_B, 8'h0b};
			default: return {`MIFC_MASK_G, 8'h03};
		endcase
	endfunction
	// flags each register should hold after a burst of events
	function automatic logic [7:0] exp_flag(input int k, input logic [6:0] e);
		case (k)
			1: return {1'b0, e[1], e[0], 5'h00};
			2: return {|e[6:5], 1'b0, e[2], |e[4:3], 4'h0};
			3: return {2'b00, e[4], e[3], 4'h0};
			default: return {2'b00, e[6], e[5], 4'h0};
		endcase
	endfunction
	task automatic give_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// a wait that ran dry ends the run
	task automatic tmo(input string s);
		n_mismatch++;
		$display("CHECK FAILED %s expected answer seen none", s);
		give_verdict();
	endtask
	// address and data offered together, each dropped once taken
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge clk_i);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; s_axi_bvalid !== 1'b1; i++) begin
			if (i > 40) tmo("write");
			@(posedge clk_i);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		int i;
		@(posedge clk_i);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; s_axi_rvalid !== 1'b1; i++) begin
			if (i > 40) tmo("read");
			@(posedge clk_i);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end
		rd = s_axi_rdata[7:0];
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic pulse(input logic [6:0] e);
		@(posedge clk_i);
		ev <= e;
		@(posedge clk_i);
		ev <= 7'h0;
		repeat (2) @(posedge clk_i);
	endtask
	// pin first, then time base 0; only the pin flag goes on service
	task automatic serve(input logic [7:0] w, input logic [2:0] v);
		int i;
		logic [7:0] c;
		c = svc_cnt;
		dly <= 4'($urandom);
		wr_reg(8'h04, w);
		for (i = 0; svc_cnt === c; i++) begin
			if (i > 60) tmo("service");
			@(posedge clk_i);
		end
		chk("vector", {5'h0, v}, {5'h0, last_vec});
		rd_reg(8'h04);
		chk("after service", 8'h26, rd);
	endtask
	initial begin
		logic [7:0] r;
		int k, t;
		void'($urandom(32'h3ceb));
		repeat (5) @(posedge clk_i);
		rstn_i <= 1'b1;
		for (k = 0; k < 8; k++) begin
			rd_reg(8'(4 * k));
			chk("reset value", 8'h00, rd);
		end
		$display("test reset done");
		for (k = 0; k < 5; k++) begin
			r = msk(k) >> 8;
			wr_reg(8'(4 * k), ~r);
			rd_reg(8'(4 * k));
			chk("unused bits", 8'h00, rd);
			r = 8'($urandom) & msk(k);
			wr_reg(8'(4 * k), r);
			rd_reg(8'(4 * k));
			chk("enable bits", r, rd);
			wr_reg(8'(4 * k), 8'h00);
		end
		wr_reg(8'h20, 8'h01);
		chk("unmapped write", {6'h0, `MIFC_RESP_SLVERR}, {6'h0, rsp});
		rd_reg(8'h24);
		chk("unmapped read", {6'h0, `MIFC_RESP_SLVERR}, {6'h0, rsp});
		$display("test access done");
		for (t = 0; t < 4; t++) begin
			r = 8'($urandom);
			pulse(r[6:0]);
			chk("no request", 8'h00, {7'h0, core_req_o});
			for (k = 1; k < 5; k++) begin
				rd_reg(8'(4 * k));
				chk("event flags", exp_flag(k, r[6:0]), rd);
			end
			for (k = 4; k > 0; k--) wr_reg(8'(4 * k), 8'h00);
		end
		$display("test events done");
		for (k = 0; k < 4; k++) begin
			wr_reg(8'h00, 8'(k));
			ext_pin_i <= 1'b1;
			repeat (6) @(posedge clk_i);
			rd_reg(8'h04);
			chk("rising pin", k[0] ? 8'h10 : 8'h00, rd);
			wr_reg(8'h04, 8'h00);
			ext_pin_i <= 1'b0;
			repeat (6) @(posedge clk_i);
			rd_reg(8'h04);
			chk("falling pin", k[1] ? 8'h10 : 8'h00, rd);
			wr_reg(8'h04, 8'h00);
		end
		$display("test edges done");
		serve(8'h37, `MIFC_VEC_PIN);
		serve(8'h27, `MIFC_VEC_TB0);
		wr_reg(8'h04, 8'h00);
		$display("test service done");
		wr_reg(8'h14, 8'h07);
		wr_reg(8'h18, 8'h02);
		pulse(7'h04);
		chk("irq raised", 8'h01, {7'h0, irq_o});
		rd_reg(8'h14);
		chk("status", 8'h02, rd);
		wr_reg(8'h14, 8'h02);
		repeat (2) @(posedge clk_i);
		chk("irq cleared", 8'h00, {7'h0, irq_o});
		wr_reg(8'h18, 8'h00);
		pulse(7'h04);
		chk("irq masked", 8'h00, {7'h0, irq_o});
		$display("test irq done");
		wr_reg(8'h04, 8'h00);
		wr_reg(8'h08, 8'h00);
		low_power_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("no wake", 8'h00, {7'h0, wake_o});
		pulse(7'h02);
		chk("wake", 8'h01, {7'h0, wake_o});
		rd_reg(8'h1c);
		chk("power", 8'h01, rd);
		low_power_i <= 1'b0;
		$display("test wake done");
		give_verdict();
	end
endmodule
`default_nettype wire
